// >>> hw/exec_defines.svh
// Purpose: named offsets, field positions, reset values and codes of the exec block
// Assumes: 32-bit AHB-Lite register window, decoded on the low address byte
// Notes:   bit numbers here are little-endian (bit 0 is the least significant)
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// register byte offsets
`define OFF_CTRL       8'h00
`define OFF_MSW        8'h04
`define OFF_FCW        8'h08
`define OFF_IRQ_STAT   8'h0C
`define OFF_IRQ_MASK   8'h10
`define OFF_W          8

// control register: configuration options
`define CTRL_SMALL     0
`define CTRL_REORDER   1
`define CTRL_BIGEND    2
`define CTRL_W         3
`define CTRL_RST       3'h4

// machine state word fields
`define MSW_CARRY      0
`define MSW_USER       1
`define MSW_VIRT       2
`define MSW_SUSER      3
`define MSW_SVIRT      4
`define MSW_W          5
`define MSW_RST        5'h00

// fault cause word fields
`define FCW_EC_LO      0
`define FCW_EC_HI      4
`define FCW_STORE      5
`define FCW_WORD       6
`define FCW_ZONE       7
`define FCW_RX_LO      8
`define FCW_RX_HI      12
`define FCW_W          13
`define FCW_RST        13'h0000

// fault cause codes
`define EC_XLATE_MISS  5'h12
`define EC_STORAGE     5'h10
`define EC_UNALIGNED   5'h01

// interrupt status bits
`define IRQ_MISS       0
`define IRQ_STORAGE    1
`define IRQ_UNALIGN    2
`define IRQ_ILLEGAL    3
`define IRQ_W          4
`define IRQ_RST        4'h0

// AHB, memory byte lane and immediate width constants
`define HTRANS_NONSEQ  1
`define BYTE_LANES     4
`define IMM_W          16

`endif

// >>> hw/exec_pkg.sv
// Purpose: types shared by the exec block and its bench
// Assumes: exec_defines.svh supplies the widths
// Notes:   the issue and lookup groups travel as packed structs
`include "exec_defines.svh"
package exec_pkg;

  // operations carried out by this block
  typedef enum logic [2:0] {
    OP_NONE            = 3'h0,
    store_byte_imm_op  = 3'h1,
    store_half_reg_op  = 3'h2,
    store_half_imm_op  = 3'h3,
    half_sign_widen_op = 3'h4,
    byte_sign_widen_op = 3'h5,
    arith_right_one_op = 3'h6,
    carry_right_one_op = 3'h7
  } op_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } state_t;

  // one instruction with its operand values
  typedef struct packed {
    op_t                 op;
    logic                rev;
    logic [4:0]          rd_num;
    logic [31:0]         first_operand_reg;
    logic [31:0]         second_operand_reg;
    logic [31:0]         src_val;
    logic [`IMM_W-1:0]   imm;
    logic                pfx_valid;
    logic [`IMM_W-1:0]   pfx_hi;
  } issue_t;

  // translation answer for the address on lookup_addr
  typedef struct packed {
    logic hit;
    logic no_access;
    logic read_only;
    logic page_rev;
  } xlate_t;

  // data memory write request
  typedef struct packed {
    logic                   we;
    logic [`BYTE_LANES-1:0] be;
    logic [31:0]            addr;
    logic [31:0]            wdata;
  } mem_req_t;

endpackage : exec_pkg

// >>> hw/store_extend_shift_exec.sv
// Purpose: byte/halfword stores, sign widening and one-bit right shifts of the core
// Assumes: translation answers combinationally for lookup_addr; one clock, sync reset
// Notes:   software sees options, state and fault words over an AHB-Lite slave
// How it works
// - byte-immediate store uses A plus widened immediate, writes low source byte.
// - sixteen-bit immediate is sign widened unless a prefix supplies upper bits.
// - virtual mode with no translation raises miss fault, code 10010, store flag.
// - virtual mode zone denial raises storage fault, code 10000, zone flag if no-access.
// - no-access denial only counts in user mode; privileged sees read-only only.
// - on miss or storage fault save user and virtual flags, then clear both.
// - check miss, then protection, then alignment; write only when none fires.
// - stores finish in one cycle, or two with the small footprint option.
// - register halfword store uses A plus B, writes low source halfword.
// - reversed halfword store swaps bytes, flipping the effective endianness.
// - reversed halfword store accepted only with reorder support enabled.
// - odd halfword address raises unaligned fault 00001, word 0, store 1, rx.
// - immediate halfword store uses A plus immediate, same checks and data.
// - halfword widen copies bit 15 of A into the upper sixteen bits.
// - byte widen copies bit 7 of A into the upper twenty-four bits.
// - arithmetic right shift keeps sign bit, shifted-out bit goes to carry.
// - carry right shift inserts old carry at top, shifted-out bit to carry.
`timescale 1ns/1ps
`include "exec_defines.svh"
module store_extend_shift_exec
  import exec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite register slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // instruction issue
  input  wire logic        issue_valid,
  input  wire issue_t      issue,
  output logic             issue_ready,
  // translation lookup
  output logic [31:0]      lookup_addr,
  input  wire xlate_t      xlate,
  // data memory and results
  output mem_req_t         mem_req,
  output logic             res_valid,
  output logic [4:0]       res_rd,
  output logic [31:0]      res_data,
  output logic             op_done,
  output logic             fault,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state and register declarations
  state_t                 state_r;
  issue_t                 op_r;
  logic [`CTRL_W-1:0]     ctrl_r;
  logic [`MSW_W-1:0]      msw_r;
  logic [`FCW_W-1:0]      fcw_r;
  logic [`IRQ_W-1:0]      irq_stat_r;
  logic [`IRQ_W-1:0]      irq_mask_r;
  logic                   wr_pend_r;
  logic [`OFF_W-1:0]      wr_off_r;

  // decode of the instruction now executing
  issue_t                 cur;
  logic                   go;
  logic                   accept;
  logic [31:0]            imm_ext;
  logic [31:0]            offset;
  logic [31:0]            addr;
  logic                   is_store;
  logic                   is_half;
  logic                   vm;
  logic                   user;
  logic                   miss;
  logic                   deny_na;
  logic                   deny_ro;
  logic                   unal;
  logic                   illegal;
  logic                   big;
  logic [1:0]             lane;
  logic [`IRQ_W-1:0]      events;
  logic                   ahb_take;
  logic [`OFF_W-1:0]      ahb_off;
  logic                   stat_read;

  ////////////////////////////////////////////////////////////////////////////////
  // issue sequencing
  // the hold state models the extra cycle of the small footprint build
  assign accept      = issue_valid && (state_r == ST_IDLE);
  assign issue_ready = (state_r == ST_IDLE);
  assign go          = (accept && !ctrl_r[`CTRL_SMALL]) || (state_r == ST_HOLD);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (accept && ctrl_r[`CTRL_SMALL]) begin
            state_r <= ST_HOLD;
          end
        end

        ST_HOLD: begin
          state_r <= ST_IDLE;
        end

        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // operand capture for the two-cycle form
  always_ff @(posedge clk) begin
    if (rst) begin
      op_r <= '0;
    end else if (accept) begin
      op_r <= issue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address formation and fault checks
  // in the hold cycle the captured copy drives everything, so issue may change
  always_comb begin
    cur      = (state_r == ST_HOLD) ? op_r : issue;
    imm_ext  = cur.pfx_valid ? {cur.pfx_hi, cur.imm}
                             : {{(32-`IMM_W){cur.imm[`IMM_W-1]}}, cur.imm};

    offset   = (cur.op == store_half_reg_op) ? cur.second_operand_reg
                                             : imm_ext;
    addr     = cur.first_operand_reg + offset;
    is_half  = (cur.op == store_half_reg_op) || (cur.op == store_half_imm_op);
    is_store = is_half || (cur.op == store_byte_imm_op);

    // live mode flags
    vm       = msw_r[`MSW_VIRT];
    user     = msw_r[`MSW_USER];

    // fault checks in priority order
    illegal  = go && is_half && cur.rev && !ctrl_r[`CTRL_REORDER];
    miss     = go && is_store && !illegal && vm && !xlate.hit;
    // no-access only bites user code; privileged code only meets read-only
    deny_na  = go && is_store && !illegal && vm && xlate.hit
               && xlate.no_access && user;
    deny_ro  = go && is_store && !illegal && vm && xlate.hit && !deny_na
               && xlate.read_only;
    unal     = go && is_half && !illegal && !miss && !deny_na && !deny_ro
               && addr[0];
  end

  assign lookup_addr = addr;

  // effective endianness: configured order, page bit in virtual mode, reverse flips it
  always_comb begin
    big  = ctrl_r[`CTRL_BIGEND] ^ (vm && xlate.page_rev) ^ (is_half && cur.rev);

    lane = big ? ~addr[1:0] : addr[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data memory write port
  // faulting stores leave we and be low, so memory never sees a partial write
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_req <= '0;
    end else begin
      mem_req.we <= 1'b0;
      mem_req.be <= '0;
      if (go && is_store && !illegal && !miss && !deny_na && !deny_ro && !unal) begin
        mem_req.we   <= 1'b1;
        mem_req.addr <= addr;

        if (is_half) begin
          mem_req.wdata <= {2{cur.src_val[15:0]}};
          mem_req.be    <= (big ^ addr[1]) ? 4'b1100 : 4'b0011;

        end else begin
          mem_req.wdata <= {4{cur.src_val[7:0]}};
          mem_req.be    <= 4'b0001 << lane;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register results of widen and shift operations
  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_rd    <= '0;
      res_data  <= '0;
    end else begin
      res_valid <= 1'b0;
      if (go && !is_store && (cur.op != OP_NONE)) begin
        res_valid <= 1'b1;
        res_rd    <= cur.rd_num;

        unique case (cur.op)
          half_sign_widen_op: begin
            res_data <= {{16{cur.first_operand_reg[15]}},
                         cur.first_operand_reg[15:0]};
          end

          byte_sign_widen_op: begin
            res_data <= {{24{cur.first_operand_reg[7]}},
                         cur.first_operand_reg[7:0]};
          end

          arith_right_one_op: begin
            res_data <= {cur.first_operand_reg[31],
                         cur.first_operand_reg[31:1]};
          end

          carry_right_one_op: begin
            res_data <= {msw_r[`MSW_CARRY],
                         cur.first_operand_reg[31:1]};
          end
          default: begin
            res_data <= res_data;
          end
        endcase
      end
    end
  end

  // completion strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      op_done <= 1'b0;
      fault   <= 1'b0;
    end else begin
      op_done <= go;

      fault   <= illegal || miss || deny_na || deny_ro || unal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_take  = hsel && hready && htrans[`HTRANS_NONSEQ];
  assign ahb_off   = haddr[`OFF_W-1:0];
  assign stat_read = ahb_take && !hwrite && (ahb_off == `OFF_IRQ_STAT);
  // hsize is not decoded: every register is one whole word

  // write address is held over into the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_off_r  <= '0;
    end else begin
      wr_pend_r <= ahb_take && hwrite;
      wr_off_r  <= ahb_off;
    end
  end

  // read data is registered in the address phase so it stands in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= '0;
    end else if (ahb_take && !hwrite) begin
      unique case (ahb_off)
        `OFF_CTRL:     hrdata <= {{(32-`CTRL_W){1'b0}}, ctrl_r};
        `OFF_MSW:      hrdata <= {{(32-`MSW_W){1'b0}}, msw_r};
        `OFF_FCW:      hrdata <= {{(32-`FCW_W){1'b0}}, fcw_r};
        `OFF_IRQ_STAT: hrdata <= {{(32-`IRQ_W){1'b0}}, irq_stat_r};
        `OFF_IRQ_MASK: hrdata <= {{(32-`IRQ_W){1'b0}}, irq_mask_r};

        default:       hrdata <= '0;
      endcase
    end
  end

  // configuration options, steered by software
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_pend_r && (wr_off_r == `OFF_CTRL)) begin
      ctrl_r <= hwdata[`CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // machine state word: a miss or storage fault or a shift beats a software write to the bits it sets in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      msw_r <= `MSW_RST;
    end else begin
      if (wr_pend_r && (wr_off_r == `OFF_MSW)) begin
        msw_r <= hwdata[`MSW_W-1:0];
      end

      if (miss || deny_na || deny_ro) begin
        msw_r[`MSW_SUSER] <= msw_r[`MSW_USER];
        msw_r[`MSW_SVIRT] <= msw_r[`MSW_VIRT];
        msw_r[`MSW_USER]  <= 1'b0;
        msw_r[`MSW_VIRT]  <= 1'b0;
      end

      if (go && ((cur.op == arith_right_one_op) || (cur.op == carry_right_one_op))) begin
        msw_r[`MSW_CARRY] <= cur.first_operand_reg[0];
      end
    end
  end

  // fault cause word; only the fields named for each fault change
  always_ff @(posedge clk) begin
    if (rst) begin
      fcw_r <= `FCW_RST;
    end else begin
      if (wr_pend_r && (wr_off_r == `OFF_FCW)) begin
        fcw_r <= hwdata[`FCW_W-1:0];
      end

      if (miss) begin
        fcw_r[`FCW_EC_HI:`FCW_EC_LO] <= `EC_XLATE_MISS;
        fcw_r[`FCW_STORE]            <= 1'b1;

      end else if (deny_na || deny_ro) begin
        fcw_r[`FCW_EC_HI:`FCW_EC_LO] <= `EC_STORAGE;
        fcw_r[`FCW_STORE]            <= 1'b1;
        fcw_r[`FCW_ZONE]             <= deny_na;

      end else if (unal) begin
        fcw_r[`FCW_EC_HI:`FCW_EC_LO] <= `EC_UNALIGNED;
        fcw_r[`FCW_WORD]             <= 1'b0;
        fcw_r[`FCW_STORE]            <= 1'b1;
        fcw_r[`FCW_RX_HI:`FCW_RX_LO] <= cur.rd_num;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status: sticky, cleared by reading it, a new event wins over the clear
  assign events = {illegal, unal, deny_na || deny_ro, miss};

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= `IRQ_RST;
    end else begin
      irq_stat_r <= (stat_read ? '0 : irq_stat_r) | events;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_r <= `IRQ_RST;
    end else if (wr_pend_r && (wr_off_r == `OFF_IRQ_MASK)) begin
      irq_mask_r <= hwdata[`IRQ_W-1:0];
    end
  end

  // level output while any unmasked event is pending
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_read ? '0 : irq_stat_r) | events) & irq_mask_r);
    end
  end

endmodule : store_extend_shift_exec

// >>> testbench/exec_monitor.sv
// Purpose: port-level assertions for the store, widen and shift block
// Assumes: one clock, synchronous active-high reset
// Notes:   the operand is kept one cycle so results can be tied to it
`timescale 1ns/1ps
module exec_monitor
  import exec_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        issue_valid,
  input wire issue_t      issue,
  input wire logic        issue_ready,
  input wire logic [31:0] lookup_addr,
  input wire mem_req_t    mem_req,
  input wire logic [31:0] res_data,
  input wire logic        op_done,
  input wire logic        fault
);
  logic [31:0] a_q;
  logic        tk;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // result checks compare against the operand of the instruction taken last edge
  always_ff @(posedge clk) a_q <= issue.first_operand_reg;
  assign tk = issue_valid && issue_ready;
  ////////////////////////////////////////////////////////////////////////////////
  a_fault_no_write: assert property (fault |-> !mem_req.we)
    else $error("write strobed with fault");
  a_lane_legal: assert property (mem_req.we |-> mem_req.be inside {1, 2, 4, 8, 3, 12})
    else $error("illegal lane set");
  a_take_answer: assert property (tk |-> ##[1:2] (op_done || fault))
    else $error("no answer after take");
  a_store_fast: assert property (tk && issue.op inside {store_byte_imm_op, store_half_reg_op,
    store_half_imm_op} ##1 issue_ready |-> mem_req.we || fault)
    else $error("store not done in one cycle");
  a_byte_imm_addr: assert property (tk && issue.op == store_byte_imm_op && !issue.pfx_valid
    |-> lookup_addr == issue.first_operand_reg + {{16{issue.imm[15]}}, issue.imm})
    else $error("byte store address wrong");
  a_prefix_addr: assert property (tk && issue.pfx_valid && issue.op != store_half_reg_op
    && issue.op inside {store_byte_imm_op, store_half_imm_op}
    |-> lookup_addr == issue.first_operand_reg + {issue.pfx_hi, issue.imm})
    else $error("prefixed address wrong");
  a_reg_addr: assert property (tk && issue.op == store_half_reg_op
    |-> lookup_addr == issue.first_operand_reg + issue.second_operand_reg)
    else $error("register address wrong");
  a_half_widen: assert property (tk && issue.op == half_sign_widen_op ##1 issue_ready
    |-> res_data == {{16{a_q[15]}}, a_q[15:0]})
    else $error("halfword widen wrong");
  a_byte_widen: assert property (tk && issue.op == byte_sign_widen_op ##1 issue_ready
    |-> res_data == {{24{a_q[7]}}, a_q[7:0]})
    else $error("byte widen wrong");
  a_arith_shift: assert property (tk && issue.op == arith_right_one_op ##1 issue_ready
    |-> res_data == {a_q[31], a_q[31:1]})
    else $error("arithmetic shift wrong");
  a_carry_shift: assert property (tk && issue.op == carry_right_one_op ##1 issue_ready
    |-> res_data[30:0] == a_q[31:1])
    else $error("carry shift wrong");
endmodule : exec_monitor

bind store_extend_shift_exec exec_monitor u_mon (
  .clk         (clk),
  .rst         (rst),
  .issue_valid (issue_valid),
  .issue       (issue),
  .issue_ready (issue_ready),
  .lookup_addr (lookup_addr),
  .mem_req     (mem_req),
  .res_data    (res_data),
  .op_done     (op_done),
  .fault       (fault)
);

// >>> testbench/mem_side_model.sv
// Purpose: data memory and translation side of the exec block
// Assumes: translation answers at once for the address on lookup_addr
// Notes:   fault knobs come from the bench; writes are only counted
`timescale 1ns/1ps
module mem_side_model
  import exec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] lookup_addr,
  input  wire mem_req_t    mem_req,
  input  wire logic        miss,
  input  wire logic        noacc,
  input  wire logic        ro,
  input  wire logic        prev,
  output xlate_t           xlate,
  output logic [7:0]       wr_count_r
);
  // upper half of the space is always mapped; tests keep to the lower half
  assign xlate = '{hit: !miss || lookup_addr[31], no_access: noacc, read_only: ro,
                   page_rev: prev};
  // counting lets the bench prove a faulting store strobed nothing
  always_ff @(posedge clk) begin
    if (rst) wr_count_r <= 8'h00;
    else if (mem_req.we) wr_count_r <= wr_count_r + 8'h01;
  end
endmodule : mem_side_model

// >>> testbench/store_extend_shift_exec_tb.sv
// Purpose: directed checks of stores, faults, widening and shifts
// Assumes: zero-wait bus slave, big endian after reset
// Notes:   every transfer waits on its handshake under a bound
`timescale 1ns/1ps
`include "exec_defines.svh"
module store_extend_shift_exec_tb;
  import exec_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, issue_valid, issue_ready;
  logic        res_valid, op_done, fault, irq, miss, noacc, ro, prev, fl, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  res_rd, rrd;
  logic [7:0]  wr_count_r, cnt0;
  logic [31:0] haddr, hwdata, hrdata, lookup_addr, res_data, rdat, q;
  issue_t      issue;
  xlate_t      xlate;
  mem_req_t    mem_req, rq;
  int          bad_count, checks_done, lat;
  op_t         wops[5] = '{half_sign_widen_op, byte_sign_widen_op, byte_sign_widen_op,
                           arith_right_one_op, carry_right_one_op};
  logic [31:0] wa[5] = '{32'h0000_8001, 32'h1234_5680, 32'hFFFF_FF7F, 32'h8000_0001,
                         32'h0000_0002};
  logic [31:0] wx[5] = '{32'hFFFF_8001, 32'hFFFF_FF80, 32'h0000_007F, 32'hC000_0000,
                         32'h8000_0001};
  logic        wc[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  assign hready = hreadyout;
  store_extend_shift_exec DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .issue_valid(issue_valid),
    .issue(issue), .issue_ready(issue_ready), .lookup_addr(lookup_addr), .xlate(xlate),
    .mem_req(mem_req), .res_valid(res_valid), .res_rd(res_rd), .res_data(res_data),
    .op_done(op_done), .fault(fault), .irq(irq));
  mem_side_model u_mem (.clk(clk), .rst(rst), .lookup_addr(lookup_addr), .mem_req(mem_req),
    .miss(miss), .noacc(noacc), .ro(ro), .prev(prev), .xlate(xlate), .wr_count_r(wr_count_r));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic timeout;
    bad_count++;
    stop_test();
  endtask : timeout
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // a hang on ready is cut short instead of stalling the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) timeout();
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input string nm, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0000_0000, q);
    check(nm, q, e);
    check("hresp", {31'd0, hresp}, 32'd0);
  endtask : rchk
  function automatic issue_t mk(op_t o, logic r, logic [31:0] a, b, s, logic [15:0] im,
                                logic pv, logic [15:0] ph);
    return '{o, r, 5'd5, a, b, s, im, pv, ph};
  endfunction : mk
  // offer, wait for the take edge, then count edges until the answer pulse
  task automatic do_op(input issue_t i);
    int n;
    n = 0;
    @(posedge clk);
    cnt0        = wr_count_r;
    issue       <= i;
    issue_valid <= 1'b1;
    @(negedge clk);
    while (issue_ready !== 1'b1) begin
      n++;
      if (n > 20) timeout();
      @(negedge clk);
    end
    @(posedge clk);
    issue_valid <= 1'b0;
    for (lat = 1; lat < 5; lat++) begin
      @(negedge clk);
      if (op_done === 1'b1 || fault === 1'b1) break;
    end
    if (lat > 4) timeout();
    rq   = mem_req;
    fl   = fault;
    rv   = res_valid;
    rdat = res_data;
    rrd  = res_rd;
  endtask : do_op
  task automatic chk_wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d,
                        input int l);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    check("latency", 32'(lat), 32'(l));
    check("addr", rq.addr, a);
    check("lanes", {28'd0, rq.be}, {28'd0, be});
    check("data", rq.wdata & m, d & m);
    @(negedge clk);
    check("writes", {24'd0, wr_count_r}, {24'd0, cnt0 + 8'h01});
  endtask : chk_wr
  task automatic chk_flt(input logic [31:0] f, m, st, input logic ie);
    check("fault", {31'd0, fl}, 32'd1);
    rchk("cause", `OFF_FCW, f);
    check("writes", {24'd0, wr_count_r}, {24'd0, cnt0});
    rchk("state", `OFF_MSW, m);
    check("irq", {31'd0, irq}, {31'd0, ie});
    rchk("status", `OFF_IRQ_STAT, st);
    rchk("status_clr", `OFF_IRQ_STAT, 32'h0000_0000);
    check("irq_clr", {31'd0, irq}, 32'd0);
  endtask : chk_flt
  task automatic vmode(input logic [31:0] m);
    wr(`OFF_FCW, 32'h0000_0000);
    wr(`OFF_MSW, m);
  endtask : vmode
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    timeout();
  end
  initial begin
    {rst, miss, noacc, ro, prev} = 5'b1_0000;
    {hsel, hwrite, htrans, haddr, hwdata, issue_valid} = '0;
    hsize = 3'b010;
    issue = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl", `OFF_CTRL, 32'h0000_0004);
    rchk("msw", `OFF_MSW, 32'h0000_0000);
    rchk("fcw", `OFF_FCW, 32'h0000_0000);
    rchk("unmapped", 32'h0000_0020, 32'h0000_0000);
    do_op(mk(store_byte_imm_op, 0, 32'h100, 0, 32'h1234_56AB, 16'hFFFC, 0, 0));
    chk_wr(32'h0000_00FC, 4'b1000, 32'hABAB_ABAB, 1);
    do_op(mk(store_byte_imm_op, 0, 32'h10, 0, 32'h5A, 16'h0002, 1, 16'h0001));
    chk_wr(32'h0001_0012, 4'b0010, 32'h5A5A_5A5A, 1);
    do_op(mk(store_half_reg_op, 0, 32'h200, 32'h4, 32'hFFFF_BEEF, 0, 0, 0));
    chk_wr(32'h0000_0204, 4'b1100, 32'hBEEF_BEEF, 1);
    do_op(mk(store_half_imm_op, 0, 32'h300, 0, 32'h1234, 16'hFFFE, 0, 0));
    chk_wr(32'h0000_02FE, 4'b0011, 32'h1234_1234, 1);
    do_op(mk(store_half_reg_op, 1, 32'h200, 0, 32'hBEEF, 0, 0, 0));
    chk_flt(32'h0000_0000, 32'h0000_0000, 32'h0000_0008, 1'b0);
    wr(`OFF_IRQ_MASK, 32'h0000_000F);
    do_op(mk(store_half_imm_op, 0, 32'h301, 0, 0, 0, 0, 0));
    chk_flt(32'h0000_0521, 32'h0000_0000, 32'h0000_0004, 1'b1);
    wr(`OFF_CTRL, 32'h0000_0006);
    do_op(mk(store_half_reg_op, 1, 32'h200, 0, 32'hBEEF, 0, 0, 0));
    chk_wr(32'h0000_0200, 4'b0011, 32'hBEEF_BEEF, 1);
    vmode(32'h0000_0006);
    miss <= 1'b1;
    do_op(mk(store_byte_imm_op, 0, 32'h60, 0, 32'h1, 0, 0, 0));
    chk_flt(32'h0000_0032, 32'h0000_0018, 32'h0000_0001, 1'b1);
    {miss, noacc} <= 2'b01;
    vmode(32'h0000_0006);
    do_op(mk(store_byte_imm_op, 0, 32'h70, 0, 32'h1, 0, 0, 0));
    chk_flt(32'h0000_00B0, 32'h0000_0018, 32'h0000_0002, 1'b1);
    vmode(32'h0000_0004);
    do_op(mk(store_byte_imm_op, 0, 32'h50, 0, 32'h11, 0, 0, 0));
    chk_wr(32'h0000_0050, 4'b1000, 32'h1111_1111, 1);
    ro <= 1'b1;
    vmode(32'h0000_0004);
    do_op(mk(store_byte_imm_op, 0, 32'h80, 0, 32'h1, 0, 0, 0));
    chk_flt(32'h0000_0030, 32'h0000_0010, 32'h0000_0002, 1'b1);
    miss <= 1'b1;
    vmode(32'h0000_0006);
    do_op(mk(store_half_imm_op, 0, 32'h91, 0, 32'h1, 0, 0, 0));
    chk_flt(32'h0000_0032, 32'h0000_0018, 32'h0000_0001, 1'b1);
    {miss, noacc, ro, prev} <= 4'b0001;
    vmode(32'h0000_0004);
    do_op(mk(store_byte_imm_op, 0, 32'h40, 0, 32'h22, 0, 0, 0));
    chk_wr(32'h0000_0040, 4'b0001, 32'h2222_2222, 1);
    prev <= 1'b0;
    wr(`OFF_MSW, 32'h0000_0000);
    for (int k = 0; k < 5; k++) begin
      do_op(mk(wops[k], 0, wa[k], 0, 0, 0, 0, 0));
      check("result", rdat, wx[k]);
      check("result_tag", {26'd0, rv, rrd}, 32'h0000_0025);
      rchk("carry", `OFF_MSW, {31'd0, wc[k]});
    end
    wr(`OFF_CTRL, 32'h0000_0005);
    do_op(mk(store_byte_imm_op, 0, 32'hA0, 0, 32'h77, 0, 0, 0));
    chk_wr(32'h0000_00A0, 4'b1000, 32'h7777_7777, 2);
    stop_test();
  end
endmodule : store_extend_shift_exec_tb
